// ---- gpiop_board.sv ----
// Purpose: board side of the twelve lines
// Assumes: no dma mux or decoder fitted, mode bits unused
// Notes:   released lines take the board level
`timescale 1ns/100ps
module gpiop_board (
    input  wire [11:0] out_i,
    input  wire [11:0] oe_i,
    input  wire [11:0] drv_i,
    output wire [11:0] pin_o
);
    localparam MUX_FIT = 1'b0;
    assign pin_o = oe_i & out_i | ~oe_i & drv_i;
endmodule

// ---- gpiop_defs.vh ----
// Purpose: constants for the general-purpose io port
// Assumes: 8-bit indexed register port
// Notes:   offsets are register indices
`ifndef GPIOP_DEFS_VH
`define GPIOP_DEFS_VH
`define GPIOP_ADDR_W        8
`define GPIOP_OFS_DATA_A    8'h90
`define GPIOP_OFS_DIR_A     8'h91
`define GPIOP_OFS_DATA_B    8'h92
`define GPIOP_OFS_DIR_B     8'h93
`define GPIOP_LINES_W       6
`define GPIOP_BIT_KBC_EN    7
`define GPIOP_BIT_DREQ_MUX  7
`define GPIOP_BIT_DACK_ENC  6
`define GPIOP_RST_DATA      6'h00
`define GPIOP_RST_DIR       6'h00
`define GPIOP_RST_MODE      1'h0
`endif

// ---- gpiop_port.v ----
// Purpose: twelve general-purpose lines in two banks of six, with mode bits
// Assumes: inputs synchronous to sys_clk_i only for timing; two-flop sync still used
// Notes:   reads return data one cycle after the read strobe
`timescale 1ns/100ps
`include "gpiop_defs.vh"

// Notes on behaviour
// - bank a output lines 0-5 driven from data register a bits 0-5
// - bank a input lines read back their sampled level in data register a
// - direction a bits 0-5: 0 input, 1 output; reset all inputs
// - direction b bits 0-5 control lines 6-11; reset all inputs
// - bank b output lines 6-11 driven from data register b bits 0-5
// - bank b input lines read back their sampled level in data register b
// - data a bit 7 routes keyboard controller ports to outputs; reset off
// - data b bit 7 selects multiplexed dma request mode; reset normal
// - data b bit 6 selects encoded dma acknowledge mode; reset normal
module gpiop_port (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // general-purpose lines, bank a is 0-5 and bank b is 6-11
    input  wire [11:0] gpio_in_i,
    output wire [11:0] gpio_out_o,
    output wire [11:0] gpio_oe_o,
    // keyboard controller port steering
    input  wire [11:0] kbc_out_i,
    input  wire [11:0] kbc_oe_i,
    // keyboard routing and dma pin modes
    output wire        kbc_route_o,
    output wire        dreq_mux_o,
    output wire        dack_enc_o
);

    reg  [5:0]  data_a_r;
    reg  [5:0]  dir_a_r;
    reg  [5:0]  data_b_r;
    reg  [5:0]  dir_b_r;
    reg         kbc_en_r;
    reg         dreq_mux_r;
    reg         dack_enc_r;
    reg  [11:0] sync1_r;
    reg  [11:0] sync2_r;
    reg  [7:0]  rdata_nxt;
    wire [11:0] dir_all;
    wire [11:0] data_all;

    // output bits from storage, input bits from the synchronised pin level
    function [5:0] merge;
        input [5:0] dir;
        input [5:0] stored;
        input [5:0] pins;
        begin
            merge = (dir & stored) | (~dir & pins);
        end
    endfunction

    assign dir_all  = {dir_b_r, dir_a_r};
    assign data_all = {data_b_r, data_a_r};
    // keyboard controller takes the lines over when routed
    assign gpio_out_o = kbc_en_r ? kbc_out_i : data_all;
    assign gpio_oe_o  = kbc_en_r ? kbc_oe_i : dir_all;
    assign kbc_route_o = kbc_en_r;
    // modes only advertise the pins; board logic must be fitted first
    assign dreq_mux_o = dreq_mux_r;
    assign dack_enc_o = dack_enc_r;

    // two-flop synchroniser, first stage read only by second
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sync1_r <= 12'h000;
            sync2_r <= 12'h000;
        end else begin
            sync1_r <= gpio_in_i;
            sync2_r <= sync1_r;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            data_a_r   <= `GPIOP_RST_DATA;
            dir_a_r    <= `GPIOP_RST_DIR;
            data_b_r   <= `GPIOP_RST_DATA;
            dir_b_r    <= `GPIOP_RST_DIR;
            kbc_en_r   <= `GPIOP_RST_MODE;
            dreq_mux_r <= `GPIOP_RST_MODE;
            dack_enc_r <= `GPIOP_RST_MODE;
        end else if (reg_wr_i) begin
            // reserved bits are simply not stored
            case (reg_addr_i)
                `GPIOP_OFS_DATA_A: begin
                    data_a_r <= reg_wdata_i[5:0];
                    kbc_en_r <= reg_wdata_i[`GPIOP_BIT_KBC_EN];
                end
                `GPIOP_OFS_DIR_A: begin
                    dir_a_r <= reg_wdata_i[5:0];
                end
                `GPIOP_OFS_DATA_B: begin
                    data_b_r   <= reg_wdata_i[5:0];
                    dreq_mux_r <= reg_wdata_i[`GPIOP_BIT_DREQ_MUX];
                    dack_enc_r <= reg_wdata_i[`GPIOP_BIT_DACK_ENC];
                end
                `GPIOP_OFS_DIR_B: begin
                    dir_b_r <= reg_wdata_i[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            `GPIOP_OFS_DATA_A:
                rdata_nxt = {kbc_en_r, 1'b0,
                             merge(dir_a_r, data_a_r, sync2_r[5:0])};
            `GPIOP_OFS_DIR_A:
                rdata_nxt = {2'b00, dir_a_r};
            `GPIOP_OFS_DATA_B:
                rdata_nxt = {dreq_mux_r, dack_enc_r,
                             merge(dir_b_r, data_b_r, sync2_r[11:6])};
            `GPIOP_OFS_DIR_B:
                rdata_nxt = {2'b00, dir_b_r};
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// ---- gpiop_props.sv ----
// Purpose: port checks of gpiop_port
// Assumes: one clock, sync reset
// Notes:   wq is last cycle's write data
`timescale 1ns/100ps
module gpiop_props (
    input wire        sys_clk_i,
    input wire        nrst_i,
    input wire [7:0]  reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    input wire [11:0] gpio_out_o,
    input wire [11:0] gpio_oe_o,
    input wire [11:0] kbc_out_i,
    input wire        kbc_route_o,
    input wire        dreq_mux_o,
    input wire        dack_enc_o
);
    reg [7:0] wq;
    always @(posedge sys_clk_i) wq <= reg_wdata_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence w(a); reg_wr_i && reg_addr_i == a; endsequence
    chk_dir_a: assert property ((w(8'h91) ##0 !kbc_route_o) |=>
        gpio_oe_o[5:0] == wq[5:0]) else $error("dir a");
    chk_dir_b: assert property ((w(8'h93) ##0 !kbc_route_o) |=>
        gpio_oe_o[11:6] == wq[5:0]) else $error("dir b");
    chk_out_a: assert property ((w(8'h90) ##0 !reg_wdata_i[7]) |=>
        ((gpio_out_o[5:0] ^ wq[5:0]) & gpio_oe_o[5:0]) == 0) else $error("out a");
    chk_out_b: assert property ((w(8'h92) ##0 !kbc_route_o) |=>
        ((gpio_out_o[11:6] ^ wq[5:0]) & gpio_oe_o[11:6]) == 0) else $error("out b");
    chk_kbc_bit: assert property (w(8'h90) |=> kbc_route_o == wq[7])
        else $error("kbc bit");
    chk_dma_modes: assert property (w(8'h92) |=> {dreq_mux_o, dack_enc_o} == wq[7:6])
        else $error("dma modes");
    chk_kbc_steer: assert property (kbc_route_o |-> gpio_out_o == kbc_out_i)
        else $error("kbc steer");
    chk_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'h91 |=>
        reg_rdata_o[7:6] == 0) else $error("reserved");
endmodule
bind gpiop_port gpiop_props gpiop_props_inst (.*);

// ---- testbench.sv ----
// Purpose: random test of gpiop_port
// Assumes: board model drives input lines
// Notes:   shadows da db wa wb give expectations
`timescale 1ns/100ps
module testbench;
    reg         clk = 0, nrst = 0, wr = 0, rd = 0;
    reg  [7:0]  ad = 0, wd = 0, wa = 0, wb = 0;
    reg  [5:0]  da = 0, db = 0;
    reg  [11:0] dv = 0, ko = 0, ke = 0;
    wire [7:0]  rq;
    wire [11:0] pin, out, oe;
    wire        kr, dm, de;
    integer     miscompares = 0, samples_checked = 0, i, j;
    always #4 clk = ~clk;
    gpiop_port gpiop_port_inst (.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rq), .gpio_in_i(pin),
        .gpio_out_o(out), .gpio_oe_o(oe), .kbc_out_i(ko), .kbc_oe_i(ke), .kbc_route_o(kr),
        .dreq_mux_o(dm), .dack_enc_o(de));
    gpiop_board gpiop_board_inst (.out_i(out), .oe_i(oe), .drv_i(dv), .pin_o(pin));
    task ck(input [11:0] s, e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task bus(input w, r, input [7:0] a, d);
        {wr, rd, ad, wd} <= {w, r, a, d};
        @(posedge clk);
    endtask
    // output lines read back the stored bit, input lines the board level
    function [7:0] ev(input [1:0] k);
        ev = k[0] ? {2'h0, k[1] ? db : da} : k[1] ? {wb[7:6], db & wb[5:0] | ~db & dv[11:6]}
            : {wa[7], 1'b0, da & wa[5:0] | ~da & dv[5:0]};
    endfunction
    task rk(input [7:0] a, e);
        bus(0, 1, a, 0);
        rd <= 0;
        #1 ck(rq, e);
        @(posedge clk);
        #1 ck(rq, 8'h00);
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        i = $urandom(10427);
        repeat (12) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        for (i = 0; i < 30; i = i + 1) begin
            for (j = 0; j < 4; j = j + 1) rk(8'h90 + j, ev(j));
            dv <= $urandom;
            {da, db, wa, wb} = {$urandom, $urandom} & 28'hfff7fff;
            bus(1, 0, 8'h91, {2'h3, da});
            bus(1, 0, 8'h93, {2'h3, db});
            bus(1, 0, 8'h90, wa | 8'h40);
            bus(1, 0, 8'h94, 8'hff);
            bus(1, 0, 8'h92, wb);
            #1 ck(oe, {db, da});
            ck(out & oe, {wb[5:0], wa[5:0]} & oe);
            ck({kr, dm, de}, {wa[7], wb[7:6]});
        end
        ko <= $urandom;
        ke <= $urandom & {db, da};
        bus(1, 0, 8'h90, wa | 8'h80);
        wa[7] = 1;
        #1 ck(out, ko);
        ck(oe, ke);
        for (j = 0; j < 4; j = j + 1) rk(8'h90 + j, ev(j));
        // mid-run reset: every register and mode output returns to zero
        nrst <= 0;
        repeat (2) @(posedge clk);
        #1 ck({kr, dm, de}, 3'h0);
        ck(oe, 12'h000);
        ck(out, 12'h000);
        {da, db, wa, wb} = 28'h0;
        nrst <= 1;
        repeat (3) @(posedge clk);
        for (j = 0; j < 4; j = j + 1) rk(8'h90 + j, ev(j));
        rk(8'h94, 8'h00);
        tally_and_finish;
    end
endmodule
